// ===== design/fueo_regs.svh
// Purpose: offsets, field positions, reset values for the flash control block
// Assumes: Avalon-MM word addressing, one register per 32-bit word
// Notes: byte address = 4 * word offset
`ifndef FUEO_REGS_SVH
`define FUEO_REGS_SVH

// Word offsets
`define FUEO_OFS_LOWER_MODE 4'h0
`define FUEO_OFS_UPPER_MODE 4'h1
`define FUEO_OFS_EBS_LOW 4'h2
`define FUEO_OFS_EBS_HIGH 4'h3
`define FUEO_OFS_RAM_OVL 4'h4
`define FUEO_OFS_STATUS 4'h5

// Lower mode control: write enables
`define FUEO_HWE_BIT 7
`define FUEO_SWE_BIT 6

// Upper mode control fields
`define FUEO_ERR_BIT 7
`define FUEO_ESU_BIT 5
`define FUEO_PSU_BIT 4
`define FUEO_EV_BIT 3
`define FUEO_PV_BIT 2
`define FUEO_EGO_BIT 1
`define FUEO_PGO_BIT 0

// Overlay control fields
`define FUEO_OVL_SEL_BIT 2
`define FUEO_OVL_AREA_MSB 1
`define FUEO_OVL_AREA_LSB 0

// Reset values
`define FUEO_MODE_RST 8'h00
`define FUEO_EBS_RST 8'h00
`define FUEO_OVL_RST 16'h0000
`define FUEO_EBS_LOW_MASK 8'h0F
`define FUEO_OVL_MASK 16'h0007

// Address map (byte addresses, 24 bits)
`define FUEO_BLK_BIG_SHIFT 15
`define FUEO_BLK7_END 24'h03EFFF
`define FUEO_SMALL_BASE 24'h03F000
`define FUEO_FLASH_END 24'h03FFFF
`define FUEO_RAM_OVL_BASE 24'hFFF800

`endif

// ===== design/fueo_pkg.sv
// Purpose: shared types for the flash control block
// Assumes: nothing beyond the register header
// Notes: block index 0..11, 15 means outside the flash
package fueo_pkg;
  typedef logic [3:0] fueo_block_t;
  typedef enum logic [1:0] {
    FUEO_BUS_IDLE = 2'b00,
    FUEO_BUS_ACK = 2'b01
  } fueo_bus_state_t;
endpackage

// ===== design/fueo_block_decode.sv
// Purpose: map a flash byte address to its erase block number
// Assumes: 24-bit CPU address
// Notes: returns 15 for addresses outside the flash
`timescale 1ns/100ps
`include "fueo_regs.svh"

module fueo_block_decode (
  // Address in
  input wire logic [23:0] addr,
  // Block out
  output fueo_pkg::fueo_block_t block,
  output logic in_flash
);

  always_comb begin
    in_flash = (addr <= `FUEO_FLASH_END);
    if (!in_flash) begin
      block = 4'hF;
    end else if (addr <= `FUEO_BLK7_END) begin
      block = {1'b0, addr[17:15]}; // 32kB blocks, block 7 cut to 28kB
    end else begin
      block = {2'b10, addr[11:10]}; // Four 1kB blocks
    end
  end

endmodule

// ===== design/fueo_overlay_map.sv
// Purpose: redirect accesses in the chosen 1kB block into the RAM window
// Assumes: overlay enable already qualified by ROM enable
// Notes: combinational; software must pause after changing the setting
`timescale 1ns/100ps
`include "fueo_regs.svh"

module fueo_overlay_map (
  // Control
  input wire logic ovl_en,
  input wire logic [1:0] ovl_area,
  // Address path
  input wire logic [23:0] addr_in,
  output logic [23:0] addr_out,
  output logic redirected
);

  logic [23:0] win_base;
  assign win_base = `FUEO_SMALL_BASE | {12'h000, ovl_area, 10'h000};

  assign redirected = ovl_en && (addr_in[23:10] == win_base[23:10]);
  assign addr_out = redirected ? (`FUEO_RAM_OVL_BASE | {14'h0000, addr_in[9:0]}) : addr_in;

endmodule

// ===== design/fueo_ctrl.sv
// Purpose: flash upper-area mode bits, erase block select and RAM overlay control
// Assumes: Avalon-MM slave, one wait state on every access
// Notes: program/erase timing lives in software; this block only gates modes
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "fueo_regs.svh"

module fueo_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Chip state
  input wire logic write_protect_pin,
  input wire logic standby,
  input wire logic flash_enable,
  input wire logic rom_enable,
  input wire logic error_set,
  // CPU address path
  input wire logic [23:0] cpu_addr,
  output logic [23:0] mem_addr,
  output logic overlay_hit,
  output logic [3:0] cpu_block,
  // Flash array controls
  output logic upper_erase_verify_mode,
  output logic upper_program_verify_mode,
  output logic upper_erase_mode,
  output logic upper_program_mode,
  output logic [11:0] block_erasable,
  output logic all_protected
);

  //////////////////////////////////////////////////////////////////////////
  // Register state

  logic sw_write_enable_q;
  logic [7:0] upper_mode_q;
  logic program_erase_error_flag_q;
  logic [3:0] ebs_low_q;
  logic [7:0] ebs_high_q;
  logic [2:0] ovl_q;
  fueo_pkg::fueo_bus_state_t bus_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;

  logic hw_write_enable;
  logic clear_cond;
  logic both_en;
  logic acc;
  logic wr_go;
  logic wr_lane0;
  logic wr_lane1;
  logic ovl_en;

  assign hw_write_enable = ~write_protect_pin;
  assign clear_cond = standby | write_protect_pin | ~sw_write_enable_q;
  assign both_en = hw_write_enable & sw_write_enable_q;
  assign acc = avs_read | avs_write;
  // Writes land in the ack cycle so data is stable and taken once
  assign wr_go = avs_write && (bus_q == fueo_pkg::FUEO_BUS_ACK);
  assign wr_lane0 = wr_go & avs_byteenable[0];
  assign wr_lane1 = wr_go & avs_byteenable[1];

  function automatic logic is_mapped(input logic [3:0] a);
    is_mapped = (a <= `FUEO_OFS_STATUS);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait state per access

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_q <= fueo_pkg::FUEO_BUS_IDLE;
    end else if (acc && bus_q == fueo_pkg::FUEO_BUS_IDLE) begin
      bus_q <= fueo_pkg::FUEO_BUS_ACK;
    end else begin
      bus_q <= fueo_pkg::FUEO_BUS_IDLE;
    end
  end

  assign avs_waitrequest = acc && (bus_q == fueo_pkg::FUEO_BUS_IDLE);

  //////////////////////////////////////////////////////////////////////////
  // Software write enable, only settable while the pin allows it

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_write_enable_q <= 1'b0;
    end else if (standby || write_protect_pin) begin
      sw_write_enable_q <= 1'b0;
    end else if (wr_lane0 && avs_address == `FUEO_OFS_LOWER_MODE) begin
      sw_write_enable_q <= avs_writedata[`FUEO_SWE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Upper mode bits; a clear on a bit is accepted while flash_enable is high

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_mode_q <= `FUEO_MODE_RST;
    end else if (clear_cond) begin
      upper_mode_q <= `FUEO_MODE_RST;
    end else if (wr_lane0 && flash_enable && avs_address == `FUEO_OFS_UPPER_MODE) begin
      upper_mode_q[`FUEO_ESU_BIT] <= avs_writedata[`FUEO_ESU_BIT] & both_en;
      upper_mode_q[`FUEO_PSU_BIT] <= avs_writedata[`FUEO_PSU_BIT] & both_en;
      upper_mode_q[`FUEO_EV_BIT] <= avs_writedata[`FUEO_EV_BIT] & both_en;
      upper_mode_q[`FUEO_PV_BIT] <= avs_writedata[`FUEO_PV_BIT] & both_en;
      upper_mode_q[`FUEO_EGO_BIT] <= avs_writedata[`FUEO_EGO_BIT] & both_en
                                     & upper_mode_q[`FUEO_ESU_BIT];
      upper_mode_q[`FUEO_PGO_BIT] <= avs_writedata[`FUEO_PGO_BIT] & both_en
                                     & upper_mode_q[`FUEO_PSU_BIT];
    end
  end

  // error flag, reset only; reset wins over set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      program_erase_error_flag_q <= 1'b0;
    end else if (error_set) begin
      program_erase_error_flag_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Erase block select registers

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ebs_high_q <= `FUEO_EBS_RST;
      ebs_low_q <= 4'h0;
    end else if (clear_cond) begin
      ebs_high_q <= `FUEO_EBS_RST;
      ebs_low_q <= 4'h0;
    end else if (wr_lane0 && flash_enable) begin
      if (avs_address == `FUEO_OFS_EBS_HIGH) begin
        ebs_high_q <= avs_writedata[7:0];
      end
      if (avs_address == `FUEO_OFS_EBS_LOW) begin
        ebs_low_q <= avs_writedata[3:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // RAM overlay control, untouched by standby

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovl_q <= 3'h0;
    end else if (wr_lane0 && avs_address == `FUEO_OFS_RAM_OVL) begin
      ovl_q <= avs_writedata[2:0];
    end
  end

  assign ovl_en = ovl_q[`FUEO_OVL_SEL_BIT] & rom_enable;

  //////////////////////////////////////////////////////////////////////////
  // Read data, captured on the wait cycle

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
      resp_q <= 2'b00;
    end else if (avs_waitrequest) begin
      rdata_q <= 32'h00000000;
      resp_q <= is_mapped(avs_address) ? 2'b00 : 2'b10;
      unique case (avs_address)
        `FUEO_OFS_LOWER_MODE: begin
          rdata_q[`FUEO_HWE_BIT] <= hw_write_enable;
          rdata_q[`FUEO_SWE_BIT] <= sw_write_enable_q;
        end
        `FUEO_OFS_UPPER_MODE: begin
          if (flash_enable) begin
            rdata_q[7:0] <= {program_erase_error_flag_q, 1'b0, upper_mode_q[5:0]};
          end
        end
        `FUEO_OFS_EBS_LOW: begin
          if (flash_enable) begin
            rdata_q[7:0] <= {4'h0, ebs_low_q};
          end
        end
        `FUEO_OFS_EBS_HIGH: begin
          if (flash_enable) begin
            rdata_q[7:0] <= ebs_high_q;
          end
        end
        `FUEO_OFS_RAM_OVL: begin
          rdata_q[15:0] <= {13'h0000, ovl_q};
        end
        `FUEO_OFS_STATUS: begin
          rdata_q[3:0] <= {upper_erase_verify_mode, upper_program_verify_mode,
                           upper_erase_mode, upper_program_mode};
          rdata_q[4] <= all_protected;
        end
        default: begin
          rdata_q <= 32'h00000000;
        end
      endcase
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_response = resp_q;

  //////////////////////////////////////////////////////////////////////////
  // Flash array controls

  assign upper_erase_verify_mode = upper_mode_q[`FUEO_EV_BIT];
  assign upper_program_verify_mode = upper_mode_q[`FUEO_PV_BIT];
  assign upper_erase_mode = upper_mode_q[`FUEO_EGO_BIT];
  assign upper_program_mode = upper_mode_q[`FUEO_PGO_BIT];

  assign all_protected = ovl_en | program_erase_error_flag_q | ~flash_enable;
  assign block_erasable = all_protected ? 12'h000 : {ebs_high_q, ebs_low_q};

  //////////////////////////////////////////////////////////////////////////
  // Address path

  fueo_overlay_map u_map (
    .ovl_en(ovl_en),
    .ovl_area(ovl_q[`FUEO_OVL_AREA_MSB:`FUEO_OVL_AREA_LSB]),
    .addr_in(cpu_addr),
    .addr_out(mem_addr),
    .redirected(overlay_hit)
  );

  fueo_block_decode u_dec (
    .addr(cpu_addr),
    .block(cpu_block),
    .in_flash()
  );

endmodule

// ===== verification/fueo_ctrl_sva.sv
// Purpose: port-level checks for the flash control block
// Assumes: one wait cycle per bus access, single clock domain
// Notes: bound onto the top module from the bench top file
`timescale 1ns/100ps
module fueo_ctrl_sva (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Chip state
  input wire logic write_protect_pin,
  input wire logic standby,
  // Address path
  input wire logic [23:0] cpu_addr,
  input wire logic [23:0] mem_addr,
  input wire logic overlay_hit,
  input wire logic [3:0] cpu_block,
  // Flash controls
  input wire logic upper_erase_verify_mode,
  input wire logic upper_program_verify_mode,
  input wire logic upper_erase_mode,
  input wire logic upper_program_mode,
  input wire logic [11:0] block_erasable,
  input wire logic all_protected
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Bus handshake: exactly one wait cycle
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait cycle");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  a_unmapped_err: assert property (avs_read && !avs_waitrequest && avs_address > 4'h5
    |-> avs_response == 2'b10 && avs_readdata == 32'h00000000) else $error("unmapped read");
  // Pin stable over the access, else the snapshot may lag
  a_hw_enable_bit: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0
    && $stable(write_protect_pin) |-> avs_readdata[7] == !write_protect_pin)
    else $error("hw enable bit");
  // Protection sources wipe modes and high select
  a_pin_clears: assert property (write_protect_pin || standby |=> block_erasable[11:4] == 8'h00
    && {upper_erase_verify_mode, upper_program_verify_mode} == 2'b00) else $error("not cleared");
  a_mode_clears: assert property (write_protect_pin || standby |=>
    {upper_erase_mode, upper_program_mode} == 2'b00) else $error("mode not cleared");
  a_protect_none: assert property (all_protected |-> block_erasable == 12'h000)
    else $error("erasable while protected");
  // Overlay window and block decode
  a_redirect_addr: assert property (overlay_hit |-> mem_addr == {14'h3FFE, cpu_addr[9:0]}
    && cpu_addr[23:12] == 12'h03F) else $error("bad redirect");
  a_pass_through: assert property (!overlay_hit |-> mem_addr == cpu_addr)
    else $error("address altered");
  a_decode_big: assert property (cpu_addr < 24'h038000 |-> cpu_block == {1'b0, cpu_addr[17:15]})
    else $error("big block");
  a_decode_small: assert property (cpu_addr[23:12] == 12'h03F
    |-> cpu_block == {2'b10, cpu_addr[11:10]}) else $error("small block");
endmodule

// ===== verification/test_flash_upper_erase_overlay_ctrl.sv
// Purpose: self-checking bench for the flash control block
// Assumes: one wait cycle per access, bench drives all ports
// Notes: table of register cases, then hand-written cases
`timescale 1ns/100ps
module test_flash_upper_erase_overlay_ctrl;
  typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e;} fueo_row_t;
  logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, write_protect_pin = 1'b0;
  logic standby = 1'b0, flash_enable = 1'b1, rom_enable = 1'b1, error_set = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF, cpu_block;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
  logic [23:0] cpu_addr = 24'h000000, mem_addr;
  logic [1:0] avs_response;
  logic [11:0] block_erasable;
  logic [15:0] rdata;
  logic avs_waitrequest, overlay_hit, all_protected, upper_erase_verify_mode;
  logic upper_program_verify_mode, upper_erase_mode, upper_program_mode;
  int mismatches = 0, comparisons = 0, cyc = 0;
  // enable first, then selects, mode bits one at a time, go bits alone and then with their setup bit
  fueo_row_t rows [13] = '{
    '{4'h0, 16'h0040, 16'h00C0}, '{4'h3, 16'h00FF, 16'h00FF}, '{4'h2, 16'h00FF, 16'h000F},
    '{4'h1, 16'h0008, 16'h0008}, '{4'h1, 16'h0004, 16'h0004}, '{4'h1, 16'h0002, 16'h0000},
    '{4'h1, 16'h0001, 16'h0000}, '{4'h1, 16'h0020, 16'h0020}, '{4'h1, 16'h0022, 16'h0022},
    '{4'h1, 16'h0010, 16'h0010}, '{4'h1, 16'h0011, 16'h0011}, '{4'h4, 16'hFFFF, 16'h0007},
    '{4'h7, 16'h00AA, 16'h0000}};
  fueo_ctrl i_dut (.*);
  always #25 clk = !clk;
  ////////////////////////////////////////
  // Compare and count
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  // One bus access, held until the rising edge that sees waitrequest low
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    // Read data taken at the completing edge, then the request is released
    rdata = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk("reg", {16'h0000, rdata}, {16'h0000, e});
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, far above the under 200 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      test_done();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Register table: write then read back
    for (int i = 0; i < 13; i++) begin
      acc(1'b1, rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    @(negedge clk);
    chk("resp", {30'h0, avs_response}, 32'h2);
    rdchk(4'h5, 16'h0011);
    @(negedge clk);
    chk("erasable", {20'h0, block_erasable}, 32'h0);
    $display("test table done");
    // Overlay ignored with ROM off: every select bit counts
    rom_enable <= 1'b0;
    @(negedge clk);
    chk("erasable", {20'h0, block_erasable}, 32'hFFF);
    @(posedge clk) rom_enable <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, 4'h4, 16'(4 + k));
      cpu_addr <= {12'h03F, 2'(k), 10'h123};
      @(negedge clk);
      chk("mem", {8'h00, mem_addr}, 32'h00FFF923);
      chk("hit", {31'h0, overlay_hit}, 32'h1);
      chk("block", {28'h0, cpu_block}, 32'(8 + k));
      @(posedge clk) cpu_addr <= {12'h03F, 2'(k ^ 1), 10'h123};
      @(negedge clk);
      chk("hit", {31'h0, overlay_hit}, 32'h0);
    end
    $display("test overlay done");
    // Standby wipes select and modes but keeps overlay
    @(posedge clk) standby <= 1'b1;
    @(posedge clk) standby <= 1'b0;
    rdchk(4'h3, 16'h0000);
    rdchk(4'h4, 16'h0007);
    rdchk(4'h1, 16'h0000);
    // Protect pin high, then software enable missing
    acc(1'b1, 4'h0, 16'h0040);
    acc(1'b1, 4'h1, 16'h0020);
    @(posedge clk) write_protect_pin <= 1'b1;
    rdchk(4'h0, 16'h0000);
    rdchk(4'h1, 16'h0000);
    @(posedge clk) write_protect_pin <= 1'b0;
    acc(1'b1, 4'h3, 16'h00FF);
    rdchk(4'h3, 16'h0000);
    $display("test protect done");
    // Flash disabled: select reads zero, writes lost
    acc(1'b1, 4'h0, 16'h0040);
    @(posedge clk) flash_enable <= 1'b0;
    acc(1'b1, 4'h3, 16'h00FF);
    rdchk(4'h3, 16'h0000);
    @(posedge clk) flash_enable <= 1'b1;
    rdchk(4'h3, 16'h0000);
    // Error flag survives pin protection, not reset
    @(posedge clk) error_set <= 1'b1;
    @(posedge clk) error_set <= 1'b0;
    @(posedge clk) write_protect_pin <= 1'b1;
    @(posedge clk) write_protect_pin <= 1'b0;
    rdchk(4'h1, 16'h0080);
    @(negedge clk);
    chk("protected", {31'h0, all_protected}, 32'h1);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rdchk(4'h1, 16'h0000);
    rdchk(4'h4, 16'h0000);
    $display("test error and reset done");
    test_done();
  end
endmodule
bind fueo_ctrl fueo_ctrl_sva i_sva (.*);
